// File: verilog/pnpdl_pkg.sv
// Summary of operation
// - Mode 0: two logical devices with memory, I/O, IRQ, DMA; three DMA channels; one enable.
// - Mode 1: five I/O+IRQ devices, DMA for two over five channels, two enables.
// - After reset take the EEPROM and hold busy high while configuring and accessing it.
// - After default load: wait-for-key, release select, clock and data pins, drop busy.
// - To reclaim, raise busy; board drops request; only then drive the EEPROM.
// - Wake from wait-for-key reads EEPROM from word 0x0E, the resource data start.
// - Each read is opcode, address, then a 16-bit data phase.
// - After reset read words 0x00 to 0x0D as defaults before any other EEPROM use.
// - Words 0x00-0x03: memory base and upper of devices 0 and 1; ignored in mode 1.
// - Words 0x04-0x08: 16-bit I/O bases of devices 0-4; devices 2-4 ignored in mode 0.
// - Word 0x09: five 3-bit block-size codes from bits 15-13 down to 3-1.
// - Block code k, capped at 6, means 2^k bytes; address bits 15 down to k compared.
// - 4-bit IRQ fields: devices 0-3 in word 0x0A, device 4 in 0x0B bits 15-12.
// - DMA channel of device 0 in word 0x0B bits 11-9, device 1 in bits 8-6.
// - Word 0x0C bits 15-11 are activation bits of devices 0 to 4.
// - Word 0x0C: enable A code 10-8, enable B code 7-5, mode bit 4.
// - Mode bit zero selects mode 0, one selects mode 1.
// - Mode 0 enable code: 000 device 0, 001 device 1, 010 either, on I/O reads.
// - Mode 1 enable codes 000-100 select the single device 0-4 whose reads drive it.
// - Word 0x0D: five 3-bit ISA channel numbers for card DMA channels 4 down to 0.
// - Reset returns to wait-for-key, reloads defaults and clears card select number.
package pnpdl_pkg;
    localparam int              SYS_CLK_MHZ   = 40;
    localparam int              SCLK_HALF_NS  = 1000;
    localparam int              SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int              TICK_W        = 6;
    localparam logic [5:0]      TICK_LAST     = 6'(SCLK_HALF_CYC - 1);
    localparam int              LD_MAX        = 5;
    localparam int              DEF_WORDS     = 14;
    localparam logic [7:0]      DEF_FIRST     = 8'h00;
    localparam logic [7:0]      DEF_LAST      = 8'h0D;
    localparam logic [7:0]      RES_START     = 8'h0E;
    localparam int              W_MEMBASE0    = 0;
    localparam int              W_MEMUP0      = 2;
    localparam int              W_IOBASE0     = 4;
    localparam int              W_BLK         = 9;
    localparam int              W_IRQ         = 10;
    localparam int              W_IRQ4        = 11;
    localparam int              W_ACT         = 12;
    localparam int              W_MAP         = 13;
    localparam int              BLK_MSB       = 15;
    localparam int              IRQ_MSB       = 15;
    localparam int              DMA0_MSB      = 11;
    localparam int              DMA1_MSB      = 8;
    localparam int              ACT_MSB       = 15;
    localparam int              OENA_MSB      = 10;
    localparam int              OENB_MSB      = 7;
    localparam int              MODE_BIT      = 4;
    localparam int              CH_MODE0      = 3;
    localparam int              CH_MODE1      = 5;
    localparam logic [2:0]      BLK_MAX       = 3'h6;
    localparam logic [2:0]      EE_READ_OP    = 3'h6;
    localparam logic [4:0]      CMD_BITS      = 5'h0B;
    localparam logic [4:0]      XFER_LAST     = 5'h1B;
    localparam logic [7:0]      REG_STATUS    = 8'h00;
    localparam logic [7:0]      REG_CONTROL   = 8'h04;
    localparam logic [7:0]      REG_CSN       = 8'h08;
    localparam logic [7:0]      REG_RESOURCE  = 8'h0C;
    localparam logic [1:0]      REG_DEF_PAGE  = 2'h1;
    localparam int              CTL_WAKE      = 0;
    localparam int              CTL_NEXT      = 1;
    localparam int              CTL_SLEEP     = 2;
    localparam logic [7:0]      CSN_RESET     = 8'h00;

    typedef enum logic [2:0] {
        ST_CLAIM    = 3'b000,
        ST_SELECT   = 3'b001,
        ST_SHIFT    = 3'b010,
        ST_DESELECT = 3'b011,
        ST_RELEASED = 3'b100
    } pnpdl_state_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pnpdl_reg_req_type;

    typedef struct packed {
        logic select;
        logic select_oe;
        logic sclk;
        logic sclk_oe;
        logic data;
        logic data_oe;
    } pnpdl_eeprom_pins_type;

    typedef struct packed {
        logic                        mode;
        logic [LD_MAX-1:0]           active;
        logic [1:0][15:0]            mem_base;
        logic [1:0][15:0]            mem_upper;
        logic [LD_MAX-1:0][15:0]     io_base;
        logic [LD_MAX-1:0][2:0]      io_block;
        logic [LD_MAX-1:0][3:0]      irq;
        logic [1:0][2:0]             dma_chan;
        logic [2:0]                  oen_a_code;
        logic [2:0]                  oen_b_code;
        logic [LD_MAX-1:0][2:0]      dma_map;
    } pnpdl_cfg_type;
endpackage

// File: verilog/pnpdl_loader.sv
`timescale 1ns/1ps
module pnpdl_loader
    import pnpdl_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire pnpdl_reg_req_type i_reg_req,
    output logic [31:0]            o_reg_rdata,
    input  wire logic              i_board_eeprom_request,
    output logic                   o_config_busy_out,
    output pnpdl_eeprom_pins_type  o_eeprom,
    input  wire logic              i_eeprom_data_io,
    input  wire logic [15:0]       i_io_addr,
    input  wire logic              i_io_read,
    input  wire logic [1:0]        i_dev_dma_req,
    input  wire logic [4:0]        i_card_dma_ack,
    output logic [1:0]             o_dev_dma_ack,
    output logic [4:0]             o_card_dma_request,
    output logic [4:0]             o_io_match,
    output logic                   o_transceiver_enable_a,
    output logic                   o_transceiver_enable_b,
    output pnpdl_cfg_type          o_cfg,
    output logic                   o_wait_for_key,
    output logic [7:0]             o_card_select_number
);

    localparam int SYNC_W = 26;

    function automatic logic [15:0] blk_mask(input logic [2:0] code);
        logic [2:0] k;
        k = (code > BLK_MAX) ? BLK_MAX : code;
        return 16'hFFFF << k;
    endfunction

    function automatic logic oen_hit(input logic mode, input logic [2:0] code, input logic [4:0] rd_hit);
        logic hit;
        hit = 1'b0;
        if (!mode) begin
            unique case (code)
                3'h0:    hit = rd_hit[0];
                3'h1:    hit = rd_hit[1];
                3'h2:    hit = rd_hit[0] | rd_hit[1];
                default: hit = 1'b0;
            endcase
        end else if (code <= 3'h4) begin
            hit = rd_hit[code];
        end
        return hit;
    endfunction

    logic [SYNC_W-1:0]     meta_q;
    logic [SYNC_W-1:0]     sync_q;
    logic                  board_req_s;
    logic                  ee_data_s;
    logic                  io_read_s;
    logic [1:0]            dev_req_s;
    logic [4:0]            card_ack_s;
    logic [15:0]           io_addr_s;

    pnpdl_state_type       state_q;
    logic [TICK_W-1:0]     tick_cnt_q;
    logic                  tick;
    logic                  engine_on;
    logic                  loading_q;
    logic                  busy_q;
    logic                  wfk_q;
    logic [7:0]            word_addr_q;
    logic [7:0]            res_addr_q;
    logic [4:0]            bit_cnt_q;
    logic                  sclk_q;
    logic                  select_q;
    logic [15:0]           shift_q;
    logic [15:0]           word_in;
    logic                  word_done;
    logic [10:0]           cmd_word;
    logic [15:0]           def_q [DEF_WORDS];
    logic [15:0]           resource_q;
    logic                  wake_pend_q;
    logic                  pend_set;
    logic                  pend_take;
    logic [7:0]            csn_q;
    logic [31:0]           rdata_q;
    logic [31:0]           rd_value;
    logic [3:0]            def_idx;
    logic                  ctl_wr;

    pnpdl_cfg_type         cfg_d;
    pnpdl_cfg_type         cfg_q;
    logic [4:0]            match_q;
    logic                  oen_a_q;
    logic                  oen_b_q;
    logic [4:0]            card_req_d;
    logic [4:0]            card_req_q;
    logic [1:0]            dev_ack_d;
    logic [1:0]            dev_ack_q;

    // Pins from the board and the EEPROM are asynchronous to the system clock.
    // No reset: a cleared request bit would look like a free EEPROM and let the
    // engine grab it from busy board logic; three reset cycles flush the pair.
    always_ff @(posedge i_sys_clk) begin
        meta_q <= {i_board_eeprom_request, i_eeprom_data_io, i_io_read, i_dev_dma_req, i_card_dma_ack, i_io_addr};
        sync_q <= meta_q;
    end

    assign {board_req_s, ee_data_s, io_read_s, dev_req_s, card_ack_s, io_addr_s} = sync_q;

    // Serial clock half period divider, runs only while the engine owns the pins
    assign engine_on = (state_q == ST_SELECT) || (state_q == ST_SHIFT) || (state_q == ST_DESELECT);
    assign tick      = engine_on && (tick_cnt_q == TICK_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !engine_on || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
        end
    end

    assign cmd_word  = {EE_READ_OP, word_addr_q};
    assign word_in   = {shift_q[14:0], ee_data_s};
    assign word_done = (state_q == ST_SHIFT) && tick && sclk_q && (bit_cnt_q == XFER_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= ST_CLAIM;
        end else begin
            unique case (state_q)
                ST_CLAIM: begin
                    if (!board_req_s) begin
                        state_q <= ST_SELECT;
                    end
                end
                ST_SELECT: begin
                    if (tick) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (word_done) begin
                        state_q <= ST_DESELECT;
                    end
                end
                ST_DESELECT: begin
                    if (tick) begin
                        state_q <= (loading_q && word_addr_q != DEF_LAST) ? ST_SELECT : ST_RELEASED;
                    end
                end
                ST_RELEASED: begin
                    if (wake_pend_q) begin
                        state_q <= ST_CLAIM;
                    end
                end
                default: state_q <= ST_CLAIM;
            endcase
        end
    end

    // Bit sequencer: data out changes with clock low, input sampled at end of high
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || state_q != ST_SHIFT) begin
            sclk_q    <= 1'b0;
            bit_cnt_q <= '0;
        end else if (tick) begin
            sclk_q <= !sclk_q;
            if (sclk_q && bit_cnt_q != XFER_LAST) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // First sampled bit is the EEPROM's dummy zero and falls off the top
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            shift_q <= '0;
        end else if (state_q == ST_SHIFT && tick && sclk_q && bit_cnt_q >= CMD_BITS) begin
            shift_q <= word_in;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            select_q <= 1'b0;
        end else if (state_q == ST_CLAIM && !board_req_s) begin
            select_q <= 1'b1;
        end else if (state_q == ST_DESELECT && tick && loading_q && word_addr_q != DEF_LAST) begin
            select_q <= 1'b1;
        end else if (word_done || state_q == ST_RELEASED) begin
            select_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            loading_q <= 1'b1;
            busy_q    <= 1'b1;
        end else if (state_q == ST_DESELECT && tick && (!loading_q || word_addr_q == DEF_LAST)) begin
            loading_q <= 1'b0;
            busy_q    <= 1'b0;
        end else if (state_q == ST_RELEASED && wake_pend_q) begin
            busy_q <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            word_addr_q <= DEF_FIRST;
        end else if (state_q == ST_DESELECT && tick && loading_q && word_addr_q != DEF_LAST) begin
            word_addr_q <= word_addr_q + 8'h01;
        end else if (state_q == ST_RELEASED && wake_pend_q) begin
            word_addr_q <= res_addr_q;
        end
    end

    // Wait-for-key: entered at reset, stays through the default load, left on wake
    assign ctl_wr    = i_reg_req.wr && (i_reg_req.addr == REG_CONTROL);
    assign pend_set  = ctl_wr && ((i_reg_req.wdata[CTL_WAKE] && wfk_q) || (i_reg_req.wdata[CTL_NEXT] && !wfk_q));
    assign pend_take = (state_q == ST_RELEASED) && wake_pend_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wfk_q <= 1'b1;
        end else if (ctl_wr && i_reg_req.wdata[CTL_WAKE] && wfk_q) begin
            wfk_q <= 1'b0;
        end else if (ctl_wr && i_reg_req.wdata[CTL_SLEEP]) begin
            wfk_q <= 1'b1;
        end
    end

    // A new request in the cycle the old one is taken still counts
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_pend_q <= 1'b0;
        end else if (pend_set) begin
            wake_pend_q <= 1'b1;
        end else if (pend_take) begin
            wake_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            res_addr_q <= RES_START;
        end else if (ctl_wr && i_reg_req.wdata[CTL_WAKE] && wfk_q) begin
            res_addr_q <= RES_START;
        end else if (word_done && !loading_q) begin
            res_addr_q <= res_addr_q + 8'h01;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            resource_q <= '0;
        end else if (word_done && !loading_q) begin
            resource_q <= word_in;
        end
    end

    // Default words are rewritten from the EEPROM after every reset
    always_ff @(posedge i_sys_clk) begin
        if (word_done && loading_q && word_addr_q <= DEF_LAST) begin
            def_q[word_addr_q[3:0]] <= word_in;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            csn_q <= CSN_RESET;
        end else if (i_reg_req.wr && i_reg_req.addr == REG_CSN) begin
            csn_q <= i_reg_req.wdata[7:0];
        end
    end

    // Decode of the default words; fields a mode ignores read as zero
    always_comb begin
        cfg_d      = '0;
        cfg_d.mode = def_q[W_ACT][MODE_BIT];
        for (int n = 0; n < LD_MAX; n++) begin
            if (n < 2 || cfg_d.mode) begin
                cfg_d.active[n]   = def_q[W_ACT][ACT_MSB - n];
                cfg_d.io_base[n]  = def_q[W_IOBASE0 + n];
                cfg_d.io_block[n] = def_q[W_BLK][BLK_MSB - 3 * n -: 3];
                cfg_d.irq[n]      = def_q[(n == 4) ? W_IRQ4 : W_IRQ][IRQ_MSB - 4 * (n % 4) -: 4];
            end
        end
        for (int m = 0; m < 2; m++) begin
            if (!cfg_d.mode) begin
                cfg_d.mem_base[m]  = def_q[W_MEMBASE0 + m];
                cfg_d.mem_upper[m] = def_q[W_MEMUP0 + m];
            end
        end
        cfg_d.dma_chan[0] = def_q[W_IRQ4][DMA0_MSB -: 3];
        cfg_d.dma_chan[1] = def_q[W_IRQ4][DMA1_MSB -: 3];
        for (int c = 0; c < LD_MAX; c++) begin
            if (c < CH_MODE0 || cfg_d.mode) begin
                cfg_d.dma_map[c] = def_q[W_MAP][3 * c +: 3];
            end
        end
        cfg_d.oen_a_code = def_q[W_ACT][OENA_MSB -: 3];
        cfg_d.oen_b_code = cfg_d.mode ? def_q[W_ACT][OENB_MSB -: 3] : 3'h0;
    end

    // Decoded set stays cleared until the whole default block is in
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || loading_q) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    for (genvar g = 0; g < LD_MAX; g++) begin : g_io_match
        always_ff @(posedge i_sys_clk) begin
            if (i_rst) begin
                match_q[g] <= 1'b0;
            end else begin
                match_q[g] <= cfg_q.active[g] &&
                    ((io_addr_s & blk_mask(cfg_q.io_block[g])) == (cfg_q.io_base[g] & blk_mask(cfg_q.io_block[g])));
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            oen_a_q <= 1'b0;
            oen_b_q <= 1'b0;
        end else begin
            oen_a_q <= oen_hit(cfg_q.mode, cfg_q.oen_a_code, match_q & {5{io_read_s}});
            oen_b_q <= cfg_q.mode && oen_hit(1'b1, cfg_q.oen_b_code, match_q & {5{io_read_s}});
        end
    end

    // Card channel c carries device n when its ISA mapping equals the device's channel
    always_comb begin
        card_req_d = '0;
        dev_ack_d  = '0;
        for (int c = 0; c < LD_MAX; c++) begin
            for (int n = 0; n < 2; n++) begin
                if ((c < CH_MODE0 || (cfg_q.mode && c < CH_MODE1)) && cfg_q.active[n] &&
                    cfg_q.dma_map[c] == cfg_q.dma_chan[n]) begin
                    card_req_d[c] = card_req_d[c] | dev_req_s[n];
                    dev_ack_d[n]  = dev_ack_d[n] | card_ack_s[c];
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            card_req_q <= '0;
            dev_ack_q  <= '0;
        end else begin
            card_req_q <= card_req_d;
            dev_ack_q  <= dev_ack_d;
        end
    end

    assign def_idx = i_reg_req.addr[5:2];

    always_comb begin
        rd_value = '0;
        if (i_reg_req.addr == REG_STATUS) begin
            rd_value = {19'h00000, cfg_q.active, 3'h0, board_req_s, cfg_q.mode, wfk_q, loading_q, busy_q};
        end else if (i_reg_req.addr == REG_CONTROL) begin
            rd_value = {29'h00000000, 1'b0, wake_pend_q, 1'b0};
        end else if (i_reg_req.addr == REG_CSN) begin
            rd_value = {24'h000000, csn_q};
        end else if (i_reg_req.addr == REG_RESOURCE) begin
            rd_value = {16'h0000, resource_q};
        end else if (i_reg_req.addr[7:6] == REG_DEF_PAGE && i_reg_req.addr[1:0] == 2'h0 &&
                     def_idx <= DEF_LAST[3:0]) begin
            rd_value = {16'h0000, def_q[def_idx]};
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !i_reg_req.rd) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_value;
        end
    end

    assign o_reg_rdata            = rdata_q;
    assign o_config_busy_out      = busy_q;
    assign o_eeprom.select        = select_q;
    assign o_eeprom.select_oe     = engine_on;
    assign o_eeprom.sclk          = sclk_q;
    assign o_eeprom.sclk_oe       = engine_on;
    assign o_eeprom.data          = (state_q == ST_SHIFT && bit_cnt_q < CMD_BITS) ? cmd_word[4'(CMD_BITS - 5'h01 - bit_cnt_q)] : 1'b0;
    assign o_eeprom.data_oe       = (state_q == ST_SELECT) || (state_q == ST_SHIFT && bit_cnt_q < CMD_BITS);
    assign o_dev_dma_ack          = dev_ack_q;
    assign o_card_dma_request     = card_req_q;
    assign o_io_match             = match_q;
    assign o_transceiver_enable_a = oen_a_q;
    assign o_transceiver_enable_b = oen_b_q;
    assign o_cfg                  = cfg_q;
    assign o_wait_for_key         = wfk_q;
    assign o_card_select_number   = csn_q;

endmodule // pnpdl_loader

// File: test/pnpdl_loader_props.sv
`timescale 1ns/1ps
module pnpdl_loader_props
    import pnpdl_pkg::*;
(
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst,
    input wire pnpdl_reg_req_type     i_reg_req,
    input wire logic                  i_board_eeprom_request,
    input wire logic                  o_config_busy_out,
    input wire pnpdl_eeprom_pins_type o_eeprom,
    input wire logic                  o_wait_for_key,
    input wire logic [7:0]            o_card_select_number
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [5:0] hi_q;
    logic [4:0] rise_q;
    logic       sclk_p_q;
    logic       sel_p_q;
    always_ff @(posedge i_sys_clk) begin
        sclk_p_q <= o_eeprom.sclk;
        sel_p_q  <= o_eeprom.select;
    end
    always_ff @(posedge i_sys_clk) hi_q <= o_eeprom.sclk ? hi_q + 6'h01 : 6'h00;
    // Counts serial clocks within one select frame
    always_ff @(posedge i_sys_clk) begin
        if (o_eeprom.select && !sel_p_q) rise_q <= 5'h00;
        else if (o_eeprom.sclk && !sclk_p_q) rise_q <= rise_q + 5'h01;
    end
    sequence s_released;
        !o_eeprom.select_oe && !o_eeprom.sclk_oe && !o_eeprom.data_oe;
    endsequence
    property p_reset_state;
        $fell(i_rst) |-> o_config_busy_out && !o_eeprom.select_oe && o_wait_for_key && o_card_select_number == 8'h00;
    endproperty
    property p_busy_drive; o_eeprom.select_oe |-> o_config_busy_out; endproperty
    property p_release; !o_config_busy_out |-> s_released; endproperty
    property p_wait_req;
        $rose(o_eeprom.select_oe) |-> !$past(i_board_eeprom_request, 3);
    endproperty
    property p_sclk_half; $fell(o_eeprom.sclk) |-> hi_q == 6'h28; endproperty
    property p_bits; $fell(o_eeprom.select) |-> rise_q == 5'h1C; endproperty
    property p_opcode;
        (o_eeprom.sclk && !sclk_p_q && rise_q < 5'h03) |-> o_eeprom.data_oe && o_eeprom.data == (rise_q != 5'h02);
    endproperty
    property p_wake;
        (i_reg_req.wr && i_reg_req.addr == REG_CONTROL && i_reg_req.wdata[CTL_WAKE] && o_wait_for_key
            && !o_config_busy_out) |-> ##[1:3] o_config_busy_out;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    a_busy_drive: assert property (p_busy_drive) else $error("driving while not busy");
    a_release: assert property (p_release) else $error("pins driven while idle");
    a_wait_req: assert property (p_wait_req) else $error("took eeprom during request");
    a_sclk_half: assert property (p_sclk_half) else $error("serial clock high half wrong");
    a_bits: assert property (p_bits) else $error("serial clocks per word wrong");
    a_opcode: assert property (p_opcode) else $error("read opcode wrong");
    a_wake: assert property (p_wake) else $error("wake did not claim eeprom");
endmodule // pnpdl_loader_props
bind pnpdl_loader pnpdl_loader_props u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_req(i_reg_req),
    .i_board_eeprom_request(i_board_eeprom_request), .o_config_busy_out(o_config_busy_out),
    .o_eeprom(o_eeprom), .o_wait_for_key(o_wait_for_key), .o_card_select_number(o_card_select_number));

// File: test/pnpdl_eeprom_model.sv
`timescale 1ns/1ps
module pnpdl_eeprom_model
    import pnpdl_pkg::*;
(
    input wire pnpdl_eeprom_pins_type i_pins,
    input wire logic                  i_sio,
    output logic                      o_oe,
    output logic                      o_d
);
    logic [15:0] mem [16] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h0300, 16'h0310, 16'h0320, 16'h0330,
                              16'h0340, 16'h6DB6, 16'h3579, 16'hBA80, 16'hFA70, 16'h578C, 16'hC3A5, 16'h0000};
    logic [10:0] cmd = 11'h000;
    int          n = 0;
    initial o_oe = 1'b0;
    initial o_d = 1'b0;
    always @(posedge i_pins.select) n = 0;
    // Released line falls to its pull-down
    always @(negedge i_pins.select) o_oe = 1'b0;
    always @(posedge i_pins.sclk) if (i_pins.select) begin
        n = n + 1;
        if (n <= 11) cmd = {cmd[9:0], i_sio};
        o_oe = n >= 12;
        // Wrong opcode or address gives inverted data
        o_d = (n > 12) ? mem[cmd[3:0]][28 - n] ^ (cmd[10:4] !== {EE_READ_OP, 4'h0}) : 1'b0;
    end
endmodule // pnpdl_eeprom_model

// File: test/pnpdl_loader_bench.sv
`timescale 1ns/1ps
module pnpdl_loader_bench;
    import pnpdl_pkg::*;
    logic clk = 0, rst = 1, breq = 1, io_rd = 0, eeprom_data_io, m_oe, m_d, ena, enb, busy, wfk;
    logic [15:0] io_a = 16'h0000;
    logic [15:0] ta [3] = '{16'h0325, 16'h0331, 16'h0328};
    logic [6:0]  te [3] = '{7'h44, 7'h28, 7'h00};
    logic [31:0] rdat;
    logic [7:0]  card_select_number;
    logic [4:0]  mt, creq, cack = 5'h00;
    logic [1:0]  dreq = 2'h0, dack;
    int          fails = 0, n_tests = 0;
    pnpdl_reg_req_type     req = '0;
    pnpdl_eeprom_pins_type pins;
    pnpdl_cfg_type         cfg;
    always #12.5 clk = ~clk;
    assign eeprom_data_io = pins.data_oe ? pins.data : (m_oe ? m_d : 1'b0);
    pnpdl_loader dut (.i_sys_clk(clk), .i_rst(rst), .i_reg_req(req), .o_reg_rdata(rdat),
        .i_board_eeprom_request(breq), .o_config_busy_out(busy), .o_eeprom(pins), .i_eeprom_data_io(eeprom_data_io),
        .i_io_addr(io_a), .i_io_read(io_rd), .i_dev_dma_req(dreq), .i_card_dma_ack(cack), .o_dev_dma_ack(dack),
        .o_card_dma_request(creq), .o_io_match(mt), .o_transceiver_enable_a(ena), .o_transceiver_enable_b(enb),
        .o_cfg(cfg), .o_wait_for_key(wfk), .o_card_select_number(card_select_number));
    pnpdl_eeprom_model ee (.i_pins(pins), .i_sio(eeprom_data_io), .o_oe(m_oe), .o_d(m_d));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
        #1 chk(rdat, e);
    endtask
    task automatic idle;
        for (int k = 0; k < 40000 && busy !== 1'b0; k++) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #2000000 fails++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        repeat (100) @(posedge clk);
        chk(pins.select_oe, 0);
        breq <= 0;
        idle;
        chk({busy, wfk, pins.select_oe, pins.sclk_oe, pins.data_oe}, 5'h08);
        for (int i = 0; i < DEF_WORDS; i++) rd(8'h40 + 8'(4 * i), ee.mem[i]);
        chk({cfg.mode, cfg.active, cfg.oen_a_code, cfg.oen_b_code}, {1'b1, ee.mem[12][15:5]});
        chk({cfg.io_base[4], cfg.irq[1], cfg.irq[4], cfg.io_block[0], cfg.dma_chan[1]}, {ee.mem[8],
            ee.mem[10][11:8], ee.mem[11][15:12], ee.mem[9][15:13], ee.mem[11][8:6]});
        chk({cfg.dma_map[4], cfg.dma_map[0], cfg.mem_base[0]},
            {ee.mem[13][14:12], ee.mem[13][2:0], 16'h0});
        foreach (ta[i]) begin
            @(posedge clk) io_a <= ta[i];
            io_rd <= 1;
            repeat (5) @(posedge clk);
            chk({ena, enb, mt}, te[i]);
        end
        dreq <= 2'h3;
        cack <= 5'h1F;
        repeat (5) @(posedge clk);
        chk({creq, dack}, 7'h41);
        wr(REG_CSN, 32'h0000005A);
        wr(REG_CONTROL, 32'h00000001);
        repeat (4) @(posedge clk);
        idle;
        rd(REG_RESOURCE, {16'h0000, ee.mem[14]});
        rd(REG_CSN, 32'h0000005A);
        rd(8'hFC, 32'h00000000);
        // Mode bit cleared for the reload after reset
        ee.mem[12] = 16'hFA60;
        @(posedge clk) rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        @(posedge clk) #1 chk({busy, wfk, card_select_number}, {2'h3, CSN_RESET});
        rd(REG_STATUS, 32'h00000007);
        @(posedge clk) io_a <= 16'h0315;
        idle;
        repeat (5) @(posedge clk);
        chk({cfg.mode, cfg.active, cfg.oen_a_code, cfg.oen_b_code, cfg.io_base[2], cfg.mem_base[1]},
            {12'h0D0, 16'h0, ee.mem[1]});
        chk({ena, enb, mt, creq, dack}, 14'h2100);
        end_sim;
    end
endmodule // pnpdl_loader_bench
